// ==== rtl/acs_device_end.sv ====
// converter end: command sequencing, sampling, fifo and mode control
`timescale 1ns/1ps
module acs_device_end
   import acs_pkg::*;
(
   // clock and reset
   input  wire logic                    clock,
   input  wire logic                    rst,
   // link to the host
   acs_link_if.dev                      link,
   // analog front end
   output logic [2:0]                   ain_channel,
   input  wire logic signed [AIN_W-1:0] ain_level,
   // status
   output logic                         busy,
   output logic                         power_down,
   output logic                         sweep_full
);

   typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_SAMPLE, ST_CONV, ST_GAP} acs_state_t;

   acs_state_t        state;
   logic [4:0]        cnt;
   logic [CMD_W-1:0]  word;
   logic [1:0]        mode;
   logic [1:0]        depth_code;
   logic [2:0]        first_ch;
   logic              step2;
   logic [2:0]        sel_ch;
   logic              ch_valid;
   logic [2:0]        seq_idx;
   logic [RES_W-1:0]  result;
   logic [RES_W-1:0]  mem [FIFO_N];
   logic [PTR_W-1:0]  wp;
   logic [PTR_W-1:0]  rp;
   logic [CNT_W-1:0]  fcount;
   // two-entry response buffer
   logic              v0;
   logic              v1;
   logic [RES_W-1:0]  d0;
   logic [RES_W-1:0]  d1;
   logic              next_v0;
   logic              next_v1;
   logic [RES_W-1:0]  next_d0;
   logic [RES_W-1:0]  next_d1;

   ////////////////////////////////////////////////////////////////////////////
   // command decode
   wire       take      = link.cmd_valid && link.cmd_ready;
   wire [3:0] op        = word[OP_HI:OP_LO];
   wire       cmd_end   = state == ST_CMD && cnt == 5'(CMD_CYC - 1);
   wire       smp_end   = state == ST_SAMPLE && cnt == 5'(SAMPLE_CYC - 1);
   wire       conv_end  = state == ST_CONV && cnt == 5'(CONV_CYC - 1);
   wire       gap_end   = state == ST_GAP && cnt == 5'(GAP_CYC - 1);
   wire       fifo_mode = mode != MODE_SINGLE;                         // see RQ11
   wire       sweeping  = mode == MODE_SWEEP || mode == MODE_RSWEEP;   // see RQ14
   wire       at_thresh = fifo_mode && fcount >= acs_depth(depth_code);
   wire       is_sel    = !op[3];
   wire       is_test   = op == OP_TEST_MID || op == OP_TEST_ZERO || op == OP_TEST_FULL;

   // a filled sweep or repeat fifo refuses conversions; repeat sweep restarts
   wire       restart   = mode == MODE_RSWEEP && at_thresh;            // see RQ7
   wire       blocked   = at_thresh && !restart;                       // see RQ5, RQ6
   // trigger without a selected channel has nothing to convert
   wire       no_chan   = op == OP_TRIG && !sweeping && !ch_valid;
   wire       conv_go   = cmd_end && acs_is_conv(op) && !blocked && !no_chan;
   wire       idx_zero  = restart || seq_idx == 3'(0);
   wire [2:0] sweep_ch  = first_ch + (idx_zero ? 3'(0) : (step2 ? {seq_idx[1:0], 1'b0}
                                                            : seq_idx));          // see RQ8
   wire [2:0] conv_ch   = sweeping ? sweep_ch : (is_sel ? op[2:0] : sel_ch);      // see RQ12

   wire       fifo_rd   = cmd_end && op == OP_FIFO_RD;
   wire       fifo_pop  = fifo_rd && fcount != '0;
   wire       fifo_push = conv_end && fifo_mode && fcount < CNT_W'(FIFO_N);      // see RQ11
   wire       cfg_wr    = cmd_end && op == OP_CFG_WR;
   wire       fifo_clr  = cfg_wr || (conv_go && restart);                        // see RQ7
   wire [RES_W-1:0] cfg_word = {mode, depth_code, first_ch, step2, 4'h0};

   ////////////////////////////////////////////////////////////////////////////
   // clipping of the front end level into the twelve-bit range
   wire signed [AIN_W-1:0] full_lvl = AIN_W'(CODE_FULL);
   wire [RES_W-1:0] clipped = ain_level < 0        ? CODE_ZERO :                 // see RQ2
                              ain_level > full_lvl ? CODE_FULL :                 // see RQ2
                              ain_level[RES_W-1:0];
   wire [RES_W-1:0] test_code = op == OP_TEST_MID  ? CODE_MID  :                 // see RQ1
                                op == OP_TEST_ZERO ? CODE_ZERO : CODE_FULL;      // see RQ1
   wire [RES_W-1:0] sampled  = is_test ? test_code : clipped;

   // response sources: config read, fifo read, single-shot result
   wire             push_cfg  = cmd_end && op == OP_CFG_RD;
   wire             push_res  = conv_end && !fifo_mode;                          // see RQ11
   wire             push      = push_cfg || fifo_rd || push_res;
   wire [RES_W-1:0] push_data = push_cfg ? cfg_word :
                                fifo_rd  ? (fcount != '0 ? mem[rp] : CODE_ZERO) : result;
   wire             pop       = v0 && link.resp_ready;

   ////////////////////////////////////////////////////////////////////////////
   // buffer next state: pop shifts, push fills first free slot
   always_comb begin
      next_v0 = v0;
      next_v1 = v1;
      next_d0 = d0;
      next_d1 = d1;
      if (pop) begin
         next_v0 = v1;
         next_d0 = d1;
         next_v1 = 1'b0;
      end
      if (push && !next_v0) begin
         next_v0 = 1'b1;
         next_d0 = push_data;
      end else if (push) begin
         next_v1 = 1'b1;
         next_d1 = push_data;
      end
   end

   // phase sequencing: command, sample window, conversion, gap
   always_ff @(posedge clock) begin
      if (rst) begin
         state <= ST_IDLE;
         cnt   <= '0;
         word  <= '0;
      end else begin
         cnt <= cnt + 5'(1);
         case (state)
            ST_IDLE: begin
               cnt <= '0;
               if (take) begin
                  state <= ST_CMD;                                     // see RQ4
                  word  <= link.cmd_word;
               end
            end
            ST_CMD: begin
               if (cmd_end) begin
                  cnt   <= '0;
                  state <= conv_go ? ST_SAMPLE : ST_IDLE;
               end
            end
            ST_SAMPLE: begin
               if (smp_end) begin                                      // see RQ3
                  cnt   <= '0;
                  state <= ST_CONV;
               end
            end
            ST_CONV: begin
               if (conv_end) begin                                     // see RQ4
                  cnt   <= '0;
                  state <= ST_GAP;
               end
            end
            ST_GAP: begin
               if (gap_end) begin                                      // see RQ4
                  cnt   <= '0;
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // configuration and channel bookkeeping
   always_ff @(posedge clock) begin
      if (rst) begin
         {mode, depth_code, first_ch, step2} <= CFG_RESET[RES_W-1:CFG_STEP_BIT];
         sel_ch   <= '0;
         ch_valid <= 1'b0;
         seq_idx  <= '0;
      end else begin
         if (cfg_wr) begin
            mode       <= word[CFG_MODE_HI:CFG_MODE_LO];               // see RQ14, RQ15
            depth_code <= word[CFG_DEPTH_HI:CFG_DEPTH_LO];
            first_ch   <= word[CFG_FIRST_HI:CFG_FIRST_LO];
            step2      <= word[CFG_STEP_BIT];
            ch_valid   <= 1'b0;                                        // see RQ10
            seq_idx    <= '0;                                          // see RQ8
         end else if (conv_go) begin
            if (is_sel) begin
               sel_ch   <= op[2:0];
               ch_valid <= 1'b1;
            end
            seq_idx <= restart ? 3'(1) : seq_idx + 3'(1);              // see RQ7
         end else if (fifo_pop && fcount == CNT_W'(1)) begin
            seq_idx <= '0;                                             // see RQ8
         end
      end
   end

   // fifo storage; the array itself needs no reset
   always_ff @(posedge clock) begin
      if (fifo_push) begin
         mem[wp] <= result;
      end
   end

   // fifo pointers and fill count
   always_ff @(posedge clock) begin
      if (rst || fifo_clr) begin
         wp     <= '0;
         rp     <= '0;
         fcount <= '0;
      end else begin
         if (fifo_push) begin
            wp <= wp + PTR_W'(1);
         end
         if (fifo_pop) begin
            rp <= rp + PTR_W'(1);
         end
         fcount <= fcount + CNT_W'(fifo_push) - CNT_W'(fifo_pop);
      end
   end

   // result capture at the end of the sampling window
   always_ff @(posedge clock) begin
      if (rst) begin
         result <= '0;
      end else if (smp_end) begin
         result <= sampled;
      end
   end

   // buffer and registered outputs
   always_ff @(posedge clock) begin
      if (rst) begin
         v0             <= 1'b0;
         v1             <= 1'b0;
         d0             <= '0;
         d1             <= '0;
         link.cmd_ready <= 1'b0;
         ain_channel    <= '0;
         busy           <= 1'b0;
         power_down     <= 1'b0;
         sweep_full     <= 1'b0;
      end else begin
         v0 <= next_v0;
         v1 <= next_v1;
         d0 <= next_d0;
         d1 <= next_d1;
         // one free slot at acceptance guarantees room for the answer
         link.cmd_ready <= (state == ST_IDLE && !take || cmd_end && !conv_go || gap_end)
                           && !next_v1;
         if (conv_go) begin
            ain_channel <= conv_ch;
         end
         busy <= !(state == ST_IDLE && !take) && !(cmd_end && !conv_go) && !gap_end;
         if (take) begin
            power_down <= 1'b0;
         end else if (cmd_end && op == OP_PWDN && !(sweeping && at_thresh)) begin // see RQ6
            power_down <= 1'b1;
         end
         sweep_full <= sweeping && fcount + CNT_W'(fifo_push) - CNT_W'(fifo_pop)
                       >= acs_depth(depth_code) && !fifo_clr && !cfg_wr;
      end
   end

   assign link.resp_valid = v0;
   assign link.resp_data  = d0;
endmodule

// ==== rtl/acs_host_end.sv ====
// host end: forwards user words, keeps channel selection and fifo draining
`timescale 1ns/1ps
module acs_host_end
   import acs_pkg::*;
(
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rst,
   // link to the converter
   acs_link_if.hst               link,
   // user requests
   input  wire logic             req_valid,
   input  wire logic [CMD_W-1:0] req_word,
   output logic                  req_ready,
   // user answers
   output logic                  resp_valid,
   output logic [RES_W-1:0]      resp_data,
   input  wire logic             resp_ready
);

   logic              hold_valid;
   logic [CMD_W-1:0]  hold_word;
   logic [1:0]        mode;
   logic [CNT_W-1:0]  thresh;
   logic              need_sel;
   logic [2:0]        last_ch;
   logic [CNT_W-1:0]  owed;

   ////////////////////////////////////////////////////////////////////////////
   // forwarding decisions for the held word
   wire [3:0] hop      = hold_word[OP_HI:OP_LO];
   wire       sent     = link.cmd_valid && link.cmd_ready;
   wire       slot     = !link.cmd_valid || link.cmd_ready;
   wire       fifo_md  = mode != MODE_SINGLE;
   wire       is_conv  = acs_is_conv(hop);
   // a conversion at threshold first drains the fifo
   wire       drain    = is_conv && fifo_md && owed >= thresh;                  // see RQ9
   wire       fix_sel  = hop == OP_TRIG && !mode[1] && need_sel;               // see RQ10
   wire       fwd      = hold_valid && slot && !drain;
   wire       drn      = hold_valid && slot && drain;
   wire [CMD_W-1:0] out_word = drn     ? {OP_FIFO_RD, 12'h000} :
                               fix_sel ? {1'b0, last_ch, hold_word[OP_LO-1:0]} : hold_word;
   wire       issue    = fwd || drn;
   wire       new_mode = fwd && hop == OP_CFG_WR;

   // answer slot towards the user
   wire       take_rsp  = link.resp_valid && link.resp_ready;
   wire       next_rv   = take_rsp || (resp_valid && !resp_ready);

   // user word holding register
   always_ff @(posedge clock) begin
      if (rst) begin
         hold_valid <= 1'b0;
         hold_word  <= '0;
         req_ready  <= 1'b0;
      end else begin
         if (req_valid && req_ready) begin
            hold_valid <= 1'b1;
            hold_word  <= req_word;
            req_ready  <= 1'b0;
         end else if (fwd) begin
            hold_valid <= 1'b0;
            req_ready  <= 1'b1;
         end else begin
            req_ready  <= !hold_valid;
         end
      end
   end

   // mode tracking, channel memory and fifo fill estimate
   always_ff @(posedge clock) begin
      if (rst) begin
         mode     <= MODE_SINGLE;
         thresh   <= acs_depth(2'b00);
         need_sel <= 1'b1;
         last_ch  <= '0;
         owed     <= '0;
      end else if (new_mode) begin
         mode     <= hold_word[CFG_MODE_HI:CFG_MODE_LO];
         thresh   <= acs_depth(hold_word[CFG_DEPTH_HI:CFG_DEPTH_LO]);
         need_sel <= 1'b1;                                             // see RQ10
         owed     <= '0;
      end else if (issue) begin
         if (fwd && !hop[3]) begin
            last_ch  <= hop[2:0];
            need_sel <= 1'b0;
         end
         if (fix_sel && fwd) begin
            need_sel <= 1'b0;
         end
         if (fwd && is_conv && fifo_md) begin
            owed <= owed + CNT_W'(1);
         end else if ((drn || hop == OP_FIFO_RD) && owed != '0) begin
            owed <= owed - CNT_W'(1);                                  // see RQ9
         end
      end
   end

   // link command register; power down goes out like any other word, with no extra cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         link.cmd_valid <= 1'b0;
         link.cmd_word  <= '0;
      end else if (issue) begin
         link.cmd_valid <= 1'b1;                                       // see RQ13
         link.cmd_word  <= out_word;
      end else if (sent) begin
         link.cmd_valid <= 1'b0;
      end
   end

   // answers to the user, one slot
   always_ff @(posedge clock) begin
      if (rst) begin
         resp_valid      <= 1'b0;
         resp_data       <= '0;
         link.resp_ready <= 1'b0;
      end else begin
         resp_valid      <= next_rv;
         link.resp_ready <= !next_rv;
         if (take_rsp) begin
            resp_data <= link.resp_data;
         end
      end
   end
endmodule

// ==== shared/acs_link_if.sv ====
// word-level link between the host serial port and the converter
`timescale 1ns/1ps
interface acs_link_if;
   import acs_pkg::*;
   logic              cmd_valid;
   logic [CMD_W-1:0]  cmd_word;
   logic              cmd_ready;
   logic              resp_valid;
   logic [RES_W-1:0]  resp_data;
   logic              resp_ready;

   modport dev (input cmd_valid, input cmd_word, output cmd_ready,
                output resp_valid, output resp_data, input resp_ready);
   modport hst (output cmd_valid, output cmd_word, input cmd_ready,
                input resp_valid, input resp_data, output resp_ready);
endinterface

// ==== shared/acs_pkg.sv ====
// constants, types and decode helpers shared by both ends of the converter link
// How it works
// RQ1: self-test words give 800h, 000h, FFFh
// RQ2: out-of-range input clips to 000h or FFFh
// RQ3: short sampling window lasts twelve serial clocks
// RQ4: command, sample, convert, then gap before next
// RQ5: sweep stops once fifo reaches threshold
// RQ6: filled sweep accepts only reads and config
// RQ7: filled repeat sweep restarts on conversion command
// RQ8: repeat sweep reruns same channel sequence
// RQ9: host drains fifo at threshold before more
// RQ10: host selects channel after single/repeat config
// RQ11: single shot bypasses fifo, repeat fills it
// RQ12: repeat mode reuses previously selected channel
// RQ13: host spends extra cycle sending power down; the host sends it with no extra cycle
// RQ14: mode 01 repeat, 10 sweep, 11 repeat sweep
// RQ15: mode 00 is single shot, no fifo
package acs_pkg;
   localparam int CMD_W   = 16;
   localparam int RES_W   = 12;
   localparam int AIN_W   = 14;
   localparam int FIFO_N  = 8;
   localparam int PTR_W   = 3;
   localparam int CNT_W   = 4;

   // opcode nibble; 0h..7h select a channel and convert it
   localparam logic [3:0] OP_TRIG      = 4'h8;
   localparam logic [3:0] OP_CFG_RD    = 4'h9;
   localparam logic [3:0] OP_CFG_WR    = 4'ha;
   localparam logic [3:0] OP_TEST_MID  = 4'hb;
   localparam logic [3:0] OP_TEST_ZERO = 4'hc;
   localparam logic [3:0] OP_TEST_FULL = 4'hd;
   localparam logic [3:0] OP_FIFO_RD   = 4'he;
   localparam logic [3:0] OP_PWDN      = 4'hf;
   localparam int         OP_HI        = 15;
   localparam int         OP_LO        = 12;

   // self-test and clip codes
   localparam logic [RES_W-1:0] CODE_MID  = 12'h800;
   localparam logic [RES_W-1:0] CODE_ZERO = 12'h000;
   localparam logic [RES_W-1:0] CODE_FULL = 12'hfff;

   // configuration word fields
   localparam int CFG_MODE_HI  = 11;
   localparam int CFG_MODE_LO  = 10;
   localparam int CFG_DEPTH_HI = 9;
   localparam int CFG_DEPTH_LO = 8;
   localparam int CFG_FIRST_HI = 7;
   localparam int CFG_FIRST_LO = 5;
   localparam int CFG_STEP_BIT = 4;
   localparam logic [RES_W-1:0] CFG_RESET = 12'h000;

   // phase lengths in serial clocks, one serial clock per system clock
   localparam int CONV_DIV   = 1;
   localparam int CMD_CYC    = 4;
   localparam int SAMPLE_CYC = 12;
   localparam int CONV_CYC   = 14 * CONV_DIV;
   localparam int GAP_CYC    = 1;

   typedef enum logic [1:0] {
      MODE_SINGLE = 2'b00,
      MODE_REPEAT = 2'b01,
      MODE_SWEEP  = 2'b10,
      MODE_RSWEEP = 2'b11
   } acs_mode_t;

   // threshold: depth code 00..11 gives 8, 6, 4, 2 words
   function automatic logic [CNT_W-1:0] acs_depth(input logic [1:0] code);
      return CNT_W'(FIFO_N) - {1'b0, code, 1'b0};
   endfunction

   // channel selects, trigger and self-test words start a conversion
   function automatic logic acs_is_conv(input logic [3:0] op);
      return !op[3] || op == OP_TRIG || op == OP_TEST_MID || op == OP_TEST_ZERO
             || op == OP_TEST_FULL;
   endfunction
endpackage

// ==== sim/acs_link_asserts.sv ====
// assertion checker watching the host-device converter link
`timescale 1ns/1ps
module acs_link_asserts
   import acs_pkg::*;
(
   // clock and reset
   input wire logic             clock,
   input wire logic             rst,
   // link signals
   input wire logic             cmd_valid,
   input wire logic [CMD_W-1:0] cmd_word,
   input wire logic             cmd_ready,
   input wire logic             resp_valid,
   input wire logic [RES_W-1:0] resp_data,
   input wire logic             resp_ready
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   // decode of the word being taken; trigger left out, the host may swap it
   logic [RES_W-1:0] cfg_q;
   logic [RES_W-1:0] code_q;
   wire              take      = cmd_valid && cmd_ready;
   wire [3:0]        op        = cmd_word[OP_HI:OP_LO];
   wire              is_test   = op == OP_TEST_MID || op == OP_TEST_ZERO || op == OP_TEST_FULL;
   wire              conv_op   = !op[3] || is_test;
   wire              single    = cfg_q[CFG_MODE_HI:CFG_MODE_LO] == 2'b00;
   wire [RES_W-1:0]  want_code = op == OP_TEST_MID ? CODE_MID :
                                 op == OP_TEST_ZERO ? CODE_ZERO : CODE_FULL;
   // shadow of the configuration and the pending self-test code
   always_ff @(posedge clock) begin
      if (rst) begin
         cfg_q  <= CFG_RESET;
         code_q <= CODE_ZERO;
      end else begin
         if (take && op == OP_CFG_WR) cfg_q <= {cmd_word[11:4], 4'h0};
         if (take && is_test) code_q <= want_code;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   chk_take_drops_ready:
      assert property (take |=> !cmd_ready)
      else $error("ready stayed high after a take");
   chk_answer_holds:
      assert property (resp_valid && !resp_ready |=> resp_valid && $stable(resp_data))
      else $error("answer changed before it was taken");
   chk_selftest_code:
      assert property (take && is_test && single && !resp_valid
                       |-> ##31 resp_valid && resp_data == code_q)
      else $error("self-test code wrong or late");
   chk_conv_latency:
      assert property (take && conv_op && single && !resp_valid
                       |-> ##30 !resp_valid ##1 resp_valid)
      else $error("single answer not at cycle 31");
   chk_ready_after_gap:
      assert property (take && conv_op && single && !resp_valid
                       |-> ##31 !cmd_ready ##1 cmd_ready)
      else $error("ready not back after the gap");
   chk_cfg_readback:
      assert property (take && op == OP_CFG_RD && !resp_valid
                       |-> ##5 resp_valid && resp_data == cfg_q)
      else $error("configuration read back wrong");
   chk_fifo_answer:
      assert property (take && op == OP_FIFO_RD && !resp_valid |-> ##5 resp_valid)
      else $error("fifo read not answered");
   chk_fifo_silent:
      assert property (take && conv_op && !single && !resp_valid |=> !resp_valid [*8])
      else $error("fifo conversion answered directly");
   // main scenarios reached
   cov_selftest: cover property (take && is_test);
   cov_fifo_read: cover property (take && op == OP_FIFO_RD && !single);
   cov_sweep_conv: cover property (take && conv_op && cfg_q[CFG_MODE_HI]);
endmodule

// ==== sim/tb_top.sv ====
// bench joining both ends of the converter link, checked against a queue model
`timescale 1ns/1ps
module tb_top
   import acs_pkg::*;
;
   // user side stimulus and observed outputs
   logic                    clock      = 1'b0;
   logic                    rst        = 1'b1;
   logic                    req_valid  = 1'b0;
   logic [CMD_W-1:0]        req_word   = '0;
   logic                    resp_ready = 1'b0;
   logic signed [AIN_W-1:0] ain_level  = '0;
   logic                    req_ready;
   logic                    resp_valid;
   logic [RES_W-1:0]        resp_data;
   logic [2:0]              ain_channel;
   logic                    busy;
   logic                    power_down;
   logic                    sweep_full;
   // model state
   int                      error_cnt  = 0;
   int                      checks     = 0;
   int                      mode, thr, first, step, idx;
   logic [RES_W-1:0]        cfgw       = CFG_RESET;
   logic [RES_W-1:0]        fifo[$];
   acs_link_if lnk ();
   ////////////////////////////////////////////////////////////////////////
   acs_host_end acs_host_end_i (.clock(clock), .rst(rst), .link(lnk.hst),
      .req_valid(req_valid), .req_word(req_word), .req_ready(req_ready),
      .resp_valid(resp_valid), .resp_data(resp_data), .resp_ready(resp_ready));
   acs_device_end acs_device_end_i (.clock(clock), .rst(rst), .link(lnk.dev),
      .ain_channel(ain_channel), .ain_level(ain_level), .busy(busy),
      .power_down(power_down), .sweep_full(sweep_full));
   acs_link_asserts acs_link_asserts_i (.clock(clock), .rst(rst),
      .cmd_valid(lnk.cmd_valid), .cmd_word(lnk.cmd_word), .cmd_ready(lnk.cmd_ready),
      .resp_valid(lnk.resp_valid), .resp_data(lnk.resp_data), .resp_ready(lnk.resp_ready));
   // 100 mhz clock
   always #5 clock = ~clock;
   ////////////////////////////////////////////////////////////////////////
   // reporting and comparison
   task automatic fail(input string msg);
      $display("MISMATCH at %0t: %s", $time, msg);
      error_cnt++;
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic cmp_data(input logic [RES_W-1:0] got, input logic [RES_W-1:0] exp);
      checks++;
      if (got !== exp) fail($sformatf("answer %h want %h", got, exp));
   endtask
   task automatic cmp_flag(input logic got, input logic exp, input string what);
      checks++;
      if (got !== exp) fail({what, " flag wrong"});
   endtask
   task automatic cmp_chan(input int ch);
      checks++;
      if (ain_channel !== 3'(ch)) fail($sformatf("channel %0d want %0d", ain_channel, ch));
   endtask
   ////////////////////////////////////////////////////////////////////////
   // user handshakes; each starts and ends just after a rising edge
   task automatic send(input logic [CMD_W-1:0] w);
      int n;
      n = 0;
      req_valid <= 1'b1;
      req_word  <= w;
      do begin
         @(posedge clock);
         n++;
      end while (req_ready !== 1'b1 && n < 300);
      if (n >= 300) fail("request never taken");
      if (n >= 300) conclude();
      req_valid <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rx(input logic [RES_W-1:0] exp);
      int n;
      n = 0;
      resp_ready <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (resp_valid !== 1'b1 && n < 300);
      if (n >= 300) fail("answer never came");
      if (n >= 300) conclude();
      cmp_data(resp_data, exp);
      resp_ready <= 1'b0;
      @(posedge clock);
   endtask
   // no answer may show while a stored conversion runs
   task automatic quiet(input int cyc);
      checks++;
      repeat (cyc) begin
         @(posedge clock);
         if (resp_valid !== 1'b0) fail("unexpected answer");
      end
   endtask
   // wait for the device to go idle so the level is not changed mid-sample
   task automatic settle();
      int n;
      n = 0;
      repeat (3) @(posedge clock);
      while ((busy !== 1'b0 || lnk.cmd_valid !== 1'b0) && n < 300) begin
         @(posedge clock);
         n++;
      end
      if (n >= 300) fail("device never went idle");
      if (n >= 300) conclude();
   endtask
   ////////////////////////////////////////////////////////////////////////
   // model-driven operations
   function automatic int rnd();
      return int'($urandom_range(4400)) - 150;
   endfunction
   task automatic conv(input logic [3:0] op, input int ch, input int lvl);
      logic [RES_W-1:0] code;
      code = lvl < 0 ? CODE_ZERO : lvl > 4095 ? CODE_FULL : RES_W'(lvl);
      ain_level <= AIN_W'(lvl);
      send({op, 12'h000});
      if (mode == 0) begin
         rx(code);
      end else begin
         fifo.push_back(code);
         quiet(8);
         settle();
      end
      cmp_chan(ch);
      cmp_flag(sweep_full, mode >= 2 && fifo.size() >= thr, "full");
   endtask
   task automatic sweep(input int n);
      repeat (n) begin
         conv(OP_TRIG, (first + idx * step) % 8, rnd());
         idx++;
      end
   endtask
   task automatic drain(input int n);
      repeat (n) begin
         send({OP_FIFO_RD, 12'h000});
         rx(fifo.size() > 0 ? fifo.pop_front() : CODE_ZERO);
         if (fifo.size() == 0) idx = 0;
         cmp_flag(sweep_full, mode >= 2 && fifo.size() >= thr, "full");
      end
   endtask
   task automatic rdcfg();
      send({OP_CFG_RD, 12'h000});
      rx(cfgw);
   endtask
   task automatic cfg(input logic [1:0] m, input logic [1:0] d, input logic [2:0] f,
                      input logic s);
      send({OP_CFG_WR, m, d, f, s, 4'h0});
      mode = m;
      thr = 8 - 2 * d;
      first = f;
      step = s ? 2 : 1;
      idx = 0;
      cfgw = {m, d, f, s, 4'h0};
      fifo.delete();
      settle();
      rdcfg();
   endtask
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      void'($urandom(10));
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      repeat (2) @(posedge clock);
      rdcfg();
      for (int i = 0; i < 3; i++) begin
         send({OP_TEST_MID + 4'(i), 12'h000});
         rx(i == 0 ? CODE_MID : i == 1 ? CODE_ZERO : CODE_FULL);
      end
      $display("test selftest done");
      send({OP_PWDN, 12'h000});
      settle();
      cmp_flag(power_down, 1'b1, "power down");
      send({OP_TEST_FULL, 12'h000});
      rx(CODE_FULL);
      cmp_flag(power_down, 1'b0, "power down");
      $display("test power down done");
      for (int ch = 0; ch < 8; ch++) begin
         conv(4'(ch), ch, ch == 0 ? -1 : ch == 1 ? 4096 : ch == 2 ? 0 : ch == 3 ? 4095 : rnd());
      end
      $display("test single shot done");
      cfg(2'b01, 2'b10, 3'h0, 1'b0);
      conv(OP_TRIG, 7, rnd());
      conv(4'h5, 5, rnd());
      repeat (2) conv(OP_TRIG, 5, rnd());
      drain(4);
      repeat (2) conv(OP_TRIG, 5, rnd());
      drain(2);
      $display("test repeat done");
      cfg(2'b10, 2'b11, 3'h6, 1'b1);
      sweep(2);
      rdcfg();
      drain(2);
      sweep(2);
      drain(2);
      $display("test sweep done");
      cfg(2'b11, 2'b11, 3'h1, 1'b0);
      sweep(2);
      drain(2);
      sweep(2);
      cfg(2'b11, 2'b11, 3'h1, 1'b0);
      drain(1);
      $display("test repeat sweep done");
      conclude();
   end
endmodule
